// ===== rtl/xma_pkg.sv
// constants, types and register map of the extended memory alu block
// assumes: apb slave on pclk, 32-bit data, byte addresses
package xma_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] XMA_CMD_OFS    = 12'h000;
  localparam logic [11:0] XMA_ADDR_OFS   = 12'h004;
  localparam logic [11:0] XMA_ACC_OFS    = 12'h008;
  localparam logic [11:0] XMA_FLAGS_OFS  = 12'h00c;
  localparam logic [11:0] XMA_STAT_OFS   = 12'h010;
  localparam logic [11:0] XMA_MADDR_OFS  = 12'h014;
  localparam logic [11:0] XMA_MDATA_OFS  = 12'h018;

  // cmd register fields
  localparam int XMA_CMD_OP_LSB  = 0;
  localparam int XMA_CMD_BIT_LSB = 8;

  // stat register fields
  localparam int XMA_STAT_BUSY = 0;
  localparam int XMA_STAT_SKIP = 1;
  localparam int XMA_STAT_BAD  = 2;

  // data memory: four sections of 128 bytes
  localparam int XMA_MEM_AW    = 9;
  localparam int XMA_MEM_WORDS = 512;

  // reset values
  localparam logic [7:0] XMA_ACC_RST   = 8'h00;
  localparam logic [5:0] XMA_FLAGS_RST = 6'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int XMA_CLK_NS         = 10;
  localparam int XMA_ICYCLE_NS      = 40;
  localparam int XMA_ICYCLE_CLKS    = XMA_ICYCLE_NS / XMA_CLK_NS;
  localparam int XMA_SKIP_ICYCLES   = 3;
  localparam int XMA_PLAIN_ICYCLES  = 1;
  localparam logic [7:0] XMA_SKIP_CNT  = 8'(XMA_SKIP_ICYCLES * XMA_ICYCLE_CLKS - 2);
  localparam logic [7:0] XMA_PLAIN_CNT = 8'(XMA_PLAIN_ICYCLES * XMA_ICYCLE_CLKS - 2);

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  localparam logic [4:0] XMA_OP_OR_M     = 5'h00;
  localparam logic [4:0] XMA_OP_RL       = 5'h01;
  localparam logic [4:0] XMA_OP_RLA      = 5'h02;
  localparam logic [4:0] XMA_OP_RLC      = 5'h03;
  localparam logic [4:0] XMA_OP_RLCA     = 5'h04;
  localparam logic [4:0] XMA_OP_RR       = 5'h05;
  localparam logic [4:0] XMA_OP_RRA      = 5'h06;
  localparam logic [4:0] XMA_OP_RRC      = 5'h07;
  localparam logic [4:0] XMA_OP_RRCA     = 5'h08;
  localparam logic [4:0] XMA_OP_SBC      = 5'h09;
  localparam logic [4:0] XMA_OP_SBCM     = 5'h0a;
  localparam logic [4:0] XMA_OP_SDZ      = 5'h0b;
  localparam logic [4:0] XMA_OP_SDZA     = 5'h0c;
  localparam logic [4:0] XMA_OP_SET      = 5'h0d;
  localparam logic [4:0] XMA_OP_SETB     = 5'h0e;
  localparam logic [4:0] XMA_OP_SIZ      = 5'h0f;
  localparam logic [4:0] XMA_OP_SIZA     = 5'h10;
  localparam logic [4:0] XMA_OP_SNZB     = 5'h11;
  localparam logic [4:0] XMA_OP_SNZ      = 5'h12;
  localparam logic [4:0] XMA_OP_SUB      = 5'h13;
  localparam logic [4:0] XMA_OP_SUBM     = 5'h14;
  localparam logic [4:0] XMA_OP_SWAP     = 5'h15;
  localparam logic [4:0] XMA_OP_SWAPA    = 5'h16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cz;
    logic sc;
    logic ov;
    logic z;
    logic ac;
    logic c;
  } xma_flags_s;

  typedef enum logic [2:0] {
    XMA_IDLE = 3'b001,
    XMA_EXEC = 3'b010,
    XMA_HOLD = 3'b100
  } xma_state_e;

endpackage

// ===== rtl/xma_core.sv
// extended memory alu block: executes one extended operation per
// command on an internal data memory, reached over apb
// assumes: single pclk domain, apb master per amba apb signalling
//
// Overview of operation
// - full address reaches any section, no bank
// - or accumulator into memory, zero flag only
// - rotate left, bit 7 to 0, no flags
// - rotate left through carry, carry only
// - rotate right, bit 0 to 7, no flags
// - rotate right through carry, carry only
// - accumulator rotates keep memory, through-carry forms still update carry
// - subtract with inverted carry borrow, six flags
// - carry clear on negative, set otherwise
// - plain subtract, same six flags
// - decrement memory, skip when zero, no flags
// - increment memory, skip when zero, no flags
// - accumulator forms keep memory, test accumulator
// - every skip operation lasts three instruction cycles
// - set byte writes ff, no flags
// - set one bit only, no flags
// - skip when selected bit nonzero, no flags
// - skip when whole byte nonzero, no flags
// - swap nibbles in place, no flags
// - accumulator swap keeps memory
//
// Register access over APB and the placing of the registers were decided locally.
module xma_core
  import xma_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // sequencer side
  output logic             skip_next,
  output logic             op_done
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]            mem_ff [XMA_MEM_WORDS];
  logic [7:0]            acc_ff;
  xma_flags_s            flags_ff;
  xma_state_e            state_ff;
  logic [4:0]            op_ff;
  logic [2:0]            bit_ff;
  logic [XMA_MEM_AW-1:0] addr_ff;
  logic [XMA_MEM_AW-1:0] maddr_ff;
  logic [7:0]            cnt_ff;
  logic                  skip_ff;
  logic                  bad_ff;
  logic                  done_ff;
  logic [31:0]           prdata_ff;
  logic                  pready_ff;
  logic                  pslverr_ff;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  wire logic acc_phase = psel & penable & ~pready_ff;
  // writes land at the edge where the master sees pready
  wire logic ack_phase = psel & penable & pready_ff;
  wire logic busy      = state_ff != XMA_IDLE;
  wire logic wr        = ack_phase & pwrite;
  wire logic sel_cmd   = hit(paddr, XMA_CMD_OFS);
  wire logic sel_addr  = hit(paddr, XMA_ADDR_OFS);
  wire logic sel_acc   = hit(paddr, XMA_ACC_OFS);
  wire logic sel_flags = hit(paddr, XMA_FLAGS_OFS);
  wire logic sel_stat  = hit(paddr, XMA_STAT_OFS);
  wire logic sel_maddr = hit(paddr, XMA_MADDR_OFS);
  wire logic sel_mdata = hit(paddr, XMA_MDATA_OFS);
  wire logic mapped    = sel_cmd | sel_addr | sel_acc | sel_flags |
                         sel_stat | sel_maddr | sel_mdata;
  wire logic wr_cmd    = wr & sel_cmd & ~busy;
  wire logic wr_addr   = wr & sel_addr & ~busy;
  wire logic wr_acc    = wr & sel_acc & ~busy;
  wire logic wr_flags  = wr & sel_flags & ~busy;
  wire logic wr_maddr  = wr & sel_maddr;
  wire logic wr_mdata  = wr & sel_mdata & ~busy;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  wire logic [7:0] opnd  = mem_ff[addr_ff];
  wire logic [7:0] bmask = 8'h01 << bit_ff;

  // subtract through an adder of the complement
  wire logic       sub_cin = (op_ff == XMA_OP_SBC || op_ff == XMA_OP_SBCM)
                             ? flags_ff.c : 1'b1;
  wire logic [8:0] sub_sum = {1'b0, acc_ff} + {1'b0, ~opnd} + {8'h00, sub_cin};
  wire logic [4:0] sub_low = {1'b0, acc_ff[3:0]} + {1'b0, ~opnd[3:0]} + {4'h0, sub_cin};
  wire logic [7:0] sub_res = sub_sum[7:0];
  wire logic       sub_ov  = (acc_ff[7] ^ opnd[7]) & (acc_ff[7] ^ sub_res[7]);
  wire logic       sub_z   = sub_res == 8'h00;
  wire logic       sub_chn = ~sub_cin | (op_ff == XMA_OP_SBC) | (op_ff == XMA_OP_SBCM);

  wire logic [7:0] rl_res  = {opnd[6:0], opnd[7]};
  wire logic [7:0] rlc_res = {opnd[6:0], flags_ff.c};
  wire logic [7:0] rr_res  = {opnd[0], opnd[7:1]};
  wire logic [7:0] rrc_res = {flags_ff.c, opnd[7:1]};
  wire logic [7:0] dec_res = opnd - 8'h01;
  wire logic [7:0] inc_res = opnd + 8'h01;
  wire logic [7:0] swp_res = {opnd[3:0], opnd[7:4]};
  wire logic [7:0] or_res  = acc_ff | opnd;

  logic [7:0] res;
  logic       to_mem;
  logic       to_acc;
  logic       is_skip;
  logic       skip_hit;
  logic       op_ok;
  xma_flags_s nxt_flags;

  always_comb begin
    res       = opnd;
    to_mem    = 1'b0;
    to_acc    = 1'b0;
    is_skip   = 1'b0;
    skip_hit  = 1'b0;
    op_ok     = 1'b1;
    nxt_flags = flags_ff;
    unique case (op_ff)
      XMA_OP_OR_M: begin
        res         = or_res;
        to_mem      = 1'b1;
        nxt_flags.z = or_res == 8'h00;
      end
      XMA_OP_RL: begin
        res    = rl_res;
        to_mem = 1'b1;
      end
      XMA_OP_RLA: begin
        res    = rl_res;
        to_acc = 1'b1;
      end
      XMA_OP_RLC, XMA_OP_RLCA: begin
        res         = rlc_res;
        to_mem      = op_ff == XMA_OP_RLC;
        to_acc      = op_ff == XMA_OP_RLCA;
        nxt_flags.c = opnd[7];
      end
      XMA_OP_RR: begin
        res    = rr_res;
        to_mem = 1'b1;
      end
      XMA_OP_RRA: begin
        res    = rr_res;
        to_acc = 1'b1;
      end
      XMA_OP_RRC, XMA_OP_RRCA: begin
        res         = rrc_res;
        to_mem      = op_ff == XMA_OP_RRC;
        to_acc      = op_ff == XMA_OP_RRCA;
        nxt_flags.c = opnd[0];
      end
      XMA_OP_SBC, XMA_OP_SBCM, XMA_OP_SUB, XMA_OP_SUBM: begin
        res          = sub_res;
        to_mem       = op_ff == XMA_OP_SBCM || op_ff == XMA_OP_SUBM;
        to_acc       = op_ff == XMA_OP_SBC || op_ff == XMA_OP_SUB;
        nxt_flags.c  = sub_sum[8];
        nxt_flags.ac = sub_low[4];
        nxt_flags.ov = sub_ov;
        nxt_flags.z  = sub_z;
        nxt_flags.sc = ~(sub_ov ^ sub_res[7]);
        nxt_flags.cz = sub_chn ? (sub_z & flags_ff.cz) : sub_z;
      end
      XMA_OP_SDZ, XMA_OP_SDZA: begin
        res      = dec_res;
        to_mem   = op_ff == XMA_OP_SDZ;
        to_acc   = op_ff == XMA_OP_SDZA;
        is_skip  = 1'b1;
        skip_hit = dec_res == 8'h00;
      end
      XMA_OP_SIZ, XMA_OP_SIZA: begin
        res      = inc_res;
        to_mem   = op_ff == XMA_OP_SIZ;
        to_acc   = op_ff == XMA_OP_SIZA;
        is_skip  = 1'b1;
        skip_hit = inc_res == 8'h00;
      end
      XMA_OP_SET: begin
        res    = 8'hff;
        to_mem = 1'b1;
      end
      XMA_OP_SETB: begin
        res    = opnd | bmask;
        to_mem = 1'b1;
      end
      XMA_OP_SNZB: begin
        is_skip  = 1'b1;
        skip_hit = (opnd & bmask) != 8'h00;
      end
      XMA_OP_SNZ: begin
        is_skip  = 1'b1;
        skip_hit = opnd != 8'h00;
      end
      XMA_OP_SWAP: begin
        res    = swp_res;
        to_mem = 1'b1;
      end
      XMA_OP_SWAPA: begin
        res    = swp_res;
        to_acc = 1'b1;
      end
      default: begin
        op_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  wire logic exec     = state_ff == XMA_EXEC;
  wire logic hold_end = (state_ff == XMA_HOLD) && (cnt_ff == 8'h00);
  wire logic mem_we   = (exec & op_ok & to_mem) | wr_mdata;
  wire logic [XMA_MEM_AW-1:0] mem_wa = exec ? addr_ff : maddr_ff;
  wire logic [7:0]            mem_wd = exec ? res : pwdata[7:0];

  xma_state_e nxt_state;
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      XMA_IDLE: if (wr_cmd) nxt_state = XMA_EXEC;
      XMA_EXEC: nxt_state = XMA_HOLD;
      XMA_HOLD: if (cnt_ff == 8'h00) nxt_state = XMA_IDLE;
      default:  nxt_state = XMA_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= XMA_IDLE;
      cnt_ff   <= 8'h00;
      op_ff    <= 5'h00;
      bit_ff   <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      if (wr_cmd) begin
        op_ff  <= pwdata[XMA_CMD_OP_LSB +: 5];
        bit_ff <= pwdata[XMA_CMD_BIT_LSB +: 3];
      end
      if (exec) cnt_ff <= is_skip ? XMA_SKIP_CNT : XMA_PLAIN_CNT;
      else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff   <= XMA_ACC_RST;
      flags_ff <= XMA_FLAGS_RST;
      skip_ff  <= 1'b0;
      bad_ff   <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= hold_end;
      if (exec) begin
        bad_ff  <= ~op_ok;
        skip_ff <= op_ok & skip_hit;
        flags_ff <= nxt_flags;
        if (op_ok & to_acc) acc_ff <= res;
      end else begin
        if (wr_acc) acc_ff <= pwdata[7:0];
        if (wr_flags) flags_ff <= pwdata[5:0];
        if (wr_cmd) skip_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff  <= '0;
      maddr_ff <= '0;
    end else begin
      if (wr_addr) addr_ff <= pwdata[XMA_MEM_AW-1:0];
      if (wr_maddr) maddr_ff <= pwdata[XMA_MEM_AW-1:0];
    end
  end

  always_ff @(posedge pclk) begin
    if (mem_we) mem_ff[mem_wa] <= mem_wd;
  end

  // ----------------------------------------------------------------
  // apb read and answer
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_cmd) rd_mux = {21'h0, bit_ff, 3'h0, op_ff};
    if (sel_addr) rd_mux = {23'h0, addr_ff};
    if (sel_acc) rd_mux = {24'h0, acc_ff};
    if (sel_flags) rd_mux = {26'h0, flags_ff};
    if (sel_stat) rd_mux = {29'h0, bad_ff, skip_ff, busy};
    if (sel_maddr) rd_mux = {23'h0, maddr_ff};
    if (sel_mdata) rd_mux = {24'h0, mem_ff[maddr_ff]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= acc_phase;
      pslverr_ff <= acc_phase & ~mapped;
      if (acc_phase & ~pwrite) prdata_ff <= rd_mux;
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign skip_next = skip_ff;
  assign op_done   = done_ff;

endmodule

// ===== verif/xma_core_props.sv
// port timing checker for xma_core
// assumes: bound to xma_core, single pclk domain
module xma_core_props
  import xma_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // sequencer side
  input wire logic        skip_next,
  input wire logic        op_done
);
  // ------------------------------------------------
  // command decode
  // ------------------------------------------------
  wire logic [4:0] cmd_op   = pwdata[4:0];
  wire logic       skip_op  = cmd_op inside {XMA_OP_SDZ, XMA_OP_SDZA, XMA_OP_SIZ,
                                             XMA_OP_SIZA, XMA_OP_SNZB, XMA_OP_SNZ};
  wire logic       plain_op = (cmd_op <= XMA_OP_SWAPA) && !skip_op;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cmd;
    psel && penable && pready && pwrite && paddr == XMA_CMD_OFS;
  endsequence
  sequence s_plain_run;
    (!op_done) [*4] ##1 op_done;
  endsequence
  sequence s_skip_run;
    (!op_done) [*8] ##1 (!op_done) [*4] ##1 op_done;
  endsequence

  chk_ready_lat: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_rdzero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("error read not zero");
  chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_done_pulse: assert property (op_done |=> !op_done)
    else $error("op_done longer than one cycle");
  chk_plain_time: assert property (s_cmd ##0 plain_op |=> s_plain_run)
    else $error("plain operation length wrong");
  chk_skip_time: assert property (s_cmd ##0 skip_op |=> s_skip_run)
    else $error("skip operation length wrong");
  chk_skip_clear: assert property (s_cmd |=> !skip_next)
    else $error("skip not cleared by new command");
  chk_plain_noskip: assert property (s_cmd ##0 plain_op |=> (!skip_next) [*5])
    else $error("plain operation raised skip");
  chk_skip_hold: assert property (op_done |-> $stable(skip_next))
    else $error("skip changed at op_done");
endmodule

bind xma_core xma_core_props u_xma_core_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .skip_next(skip_next), .op_done(op_done));

// ===== verif/xma_seq_model.sv
// sequencer model: tallies instructions discarded after skips
// assumes: pclk domain of xma_core, outputs sampled at op_done
module xma_seq_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // block outcome
  input  wire logic       skip_next,
  input  wire logic       op_done,
  // discard tally
  output logic      [7:0] discard_ff
);
  // next fetch dropped when skip stands at done
  wire logic [7:0] nxt_discard = discard_ff + {7'h0, skip_next};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discard_ff <= 8'h00;
    end else if (op_done) begin
      discard_ff <= nxt_discard;
    end
  end
endmodule

// ===== verif/xma_core_tb_top.sv
// self-checking bench for xma_core
// assumes: xma_core_props bound, xma_seq_model watches sequencer side
module xma_core_tb_top
  import xma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, skip_next, op_done, perr;
  logic [7:0] discard_ff;
  int failures = 0, check_count = 0, disc_exp = 0;

  always #5 pclk = ~pclk;

  xma_core u_xma_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .skip_next(skip_next), .op_done(op_done));
  xma_seq_model u_xma_seq_model (.pclk(pclk), .presetn(presetn), .skip_next(skip_next),
    .op_done(op_done), .discard_ff(discard_ff));

  // ------------------------------------------------
  // shared tasks
  // ------------------------------------------------
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      failures++;
      stop_test();
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [22:0] ref_op(logic [4:0] op, logic [2:0] b, logic [7:0] m,
                                         logic [7:0] a, logic [5:0] f);
    logic [7:0] nm, na, r; logic sk, bw; logic [8:0] d; logic [4:0] h; xma_flags_s fl;
    nm = m; na = a; sk = 1'b0; fl = f;
    bw = (op == XMA_OP_SBC || op == XMA_OP_SBCM) ? ~f[0] : 1'b0;
    d = {1'b0, a} - {1'b0, m} - {8'h0, bw};
    h = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, bw};
    r = d[7:0];
    case (op)
      XMA_OP_OR_M: begin nm = a | m; fl.z = (nm == 8'h00); end
      XMA_OP_RL:   nm = {m[6:0], m[7]};
      XMA_OP_RLA:  na = {m[6:0], m[7]};
      XMA_OP_RLC:  begin nm = {m[6:0], f[0]}; fl.c = m[7]; end
      XMA_OP_RLCA: begin na = {m[6:0], f[0]}; fl.c = m[7]; end
      XMA_OP_RR:   nm = {m[0], m[7:1]};
      XMA_OP_RRA:  na = {m[0], m[7:1]};
      XMA_OP_RRC:  begin nm = {f[0], m[7:1]}; fl.c = m[0]; end
      XMA_OP_RRCA: begin na = {f[0], m[7:1]}; fl.c = m[0]; end
      XMA_OP_SBC, XMA_OP_SBCM, XMA_OP_SUB, XMA_OP_SUBM: begin
        fl.c = ~d[8]; fl.ac = ~h[4]; fl.z = (r == 8'h00);
        fl.ov = (a[7] ^ m[7]) & (a[7] ^ r[7]); fl.sc = ~(fl.ov ^ r[7]);
        fl.cz = (op == XMA_OP_SBC || op == XMA_OP_SBCM) ? fl.z & f[5] : fl.z;
        if (op == XMA_OP_SBCM || op == XMA_OP_SUBM) nm = r; else na = r;
      end
      XMA_OP_SDZ:  begin nm = m - 8'h01; sk = (nm == 8'h00); end
      XMA_OP_SDZA: begin na = m - 8'h01; sk = (na == 8'h00); end
      XMA_OP_SIZ:  begin nm = m + 8'h01; sk = (nm == 8'h00); end
      XMA_OP_SIZA: begin na = m + 8'h01; sk = (na == 8'h00); end
      XMA_OP_SET:  nm = 8'hff;
      XMA_OP_SETB: nm[b] = 1'b1;
      XMA_OP_SNZB: sk = m[b];
      XMA_OP_SNZ:  sk = (m != 8'h00);
      XMA_OP_SWAP: nm = {m[3:0], m[7:4]};
      XMA_OP_SWAPA: na = {m[3:0], m[7:4]};
      default: ;
    endcase
    return {sk, fl, na, nm};
  endfunction

  // runs one operation and compares every result
  task automatic chk_op(input logic [4:0] op, input logic [2:0] b, input logic [8:0] ad,
                        input logic [7:0] m, input logic [7:0] a, input logic [5:0] f);
    logic [22:0] e; int n, nexp;
    e = ref_op(op, b, m, a, f);
    nexp = (op inside {XMA_OP_SDZ, XMA_OP_SDZA, XMA_OP_SIZ, XMA_OP_SIZA, XMA_OP_SNZB,
            XMA_OP_SNZ}) ? XMA_SKIP_ICYCLES * XMA_ICYCLE_CLKS : XMA_ICYCLE_CLKS;
    apb(1'b1, XMA_MADDR_OFS, {23'h0, ad});
    apb(1'b1, XMA_MDATA_OFS, {24'h0, m});
    apb(1'b1, XMA_ACC_OFS, {24'h0, a});
    apb(1'b1, XMA_FLAGS_OFS, {26'h0, f});
    apb(1'b1, XMA_ADDR_OFS, {23'h0, ad});
    apb(1'b1, XMA_CMD_OFS, {21'h0, b, 3'h0, op});
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (op_done !== 1'b1 && n < 40);
    if (n >= 40) begin
      failures++;
      stop_test();
    end
    cmp("cycles", nexp, n);
    cmp("skip_port", {31'h0, e[22]}, {31'h0, skip_next});
    disc_exp += e[22];
    apb(1'b0, XMA_ACC_OFS, 32'h0);
    cmp("acc", {24'h0, e[15:8]}, rdat);
    apb(1'b0, XMA_FLAGS_OFS, 32'h0);
    cmp("flags", {26'h0, e[21:16]}, rdat);
    apb(1'b0, XMA_MDATA_OFS, 32'h0);
    cmp("mem", {24'h0, e[7:0]}, rdat);
    apb(1'b0, XMA_STAT_OFS, 32'h0);
    cmp("stat_skip", {31'h0, e[22]}, {31'h0, rdat[XMA_STAT_SKIP]});
    cmp("stat_bad", {31'h0, op > XMA_OP_SWAPA}, {31'h0, rdat[XMA_STAT_BAD]});
  endtask

  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_bus;
    apb(1'b0, XMA_ACC_OFS, 32'h0);
    cmp("acc_reset", {24'h0, XMA_ACC_RST}, rdat);
    apb(1'b0, 12'h01c, 32'h0);
    cmp("unmapped_err", 32'h1, {31'h0, perr});
    cmp("unmapped_data", 32'h0, rdat);
  endtask

  task automatic t_logic;
    chk_op(XMA_OP_OR_M, 3'h0, 9'h1a5, 8'h0f, 8'h30, 6'h04);
    chk_op(XMA_OP_OR_M, 3'h0, 9'h001, 8'h00, 8'h00, 6'h3b);
    chk_op(XMA_OP_SET, 3'h0, 9'h0c0, 8'h12, 8'h34, 6'h2a);
    chk_op(XMA_OP_SETB, 3'h7, 9'h140, 8'h01, 8'h00, 6'h15);
    chk_op(XMA_OP_SETB, 3'h0, 9'h141, 8'hf0, 8'h00, 6'h2a);
    chk_op(XMA_OP_SWAP, 3'h0, 9'h055, 8'h3c, 8'h99, 6'h3f);
    chk_op(XMA_OP_SWAPA, 3'h0, 9'h056, 8'ha5, 8'h00, 6'h00);
    chk_op(5'h1f, 3'h0, 9'h057, 8'h5a, 8'h33, 6'h2a);
  endtask

  task automatic t_rotate;
    for (int i = 1; i <= 8; i++) begin
      chk_op(5'(i), 3'h0, 9'h0ff, 8'h81, 8'h5a, 6'h2a);
      chk_op(5'(i), 3'h0, 9'h17e, 8'h42, 8'h5a, 6'h15);
    end
  endtask

  task automatic t_sub;
    chk_op(XMA_OP_SBC, 3'h0, 9'h010, 8'h10, 8'h10, 6'h20);
    chk_op(XMA_OP_SBC, 3'h0, 9'h011, 8'h10, 8'h10, 6'h21);
    chk_op(XMA_OP_SBCM, 3'h0, 9'h190, 8'h01, 8'h80, 6'h21);
    chk_op(XMA_OP_SUB, 3'h0, 9'h012, 8'h33, 8'h33, 6'h00);
    chk_op(XMA_OP_SUBM, 3'h0, 9'h013, 8'h09, 8'h12, 6'h3f);
  endtask

  task automatic t_skip;
    chk_op(XMA_OP_SDZ, 3'h0, 9'h020, 8'h01, 8'h77, 6'h2a);
    chk_op(XMA_OP_SDZ, 3'h0, 9'h021, 8'h00, 8'h77, 6'h15);
    chk_op(XMA_OP_SDZA, 3'h0, 9'h122, 8'h01, 8'h77, 6'h2a);
    chk_op(XMA_OP_SIZ, 3'h0, 9'h023, 8'hff, 8'h77, 6'h15);
    chk_op(XMA_OP_SIZA, 3'h0, 9'h124, 8'hfe, 8'h77, 6'h2a);
    chk_op(XMA_OP_SNZB, 3'h3, 9'h025, 8'h08, 8'h00, 6'h15);
    chk_op(XMA_OP_SNZB, 3'h3, 9'h026, 8'hf7, 8'h00, 6'h2a);
    chk_op(XMA_OP_SNZ, 3'h0, 9'h027, 8'h00, 8'h00, 6'h15);
    chk_op(XMA_OP_SNZ, 3'h0, 9'h1ff, 8'h40, 8'h00, 6'h2a);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_bus();
    t_logic();
    t_rotate();
    t_sub();
    t_skip();
    cmp("discards", disc_exp, {24'h0, discard_ff});
    stop_test();
  end
endmodule
